// file: hdl/camera_capture_pkg.sv
// Constants, register map and state types for the camera capture control
package camera_capture_pkg;
  // Sensor array geometry
  localparam int ROW_W = 8;
  localparam int COL_W = 8;
  localparam int PIX_W = 8;
  // Two-wire configuration addressing, 8-bit notation
  localparam logic [7:0] DEV_ADDR_BASE = 8'h90;
  localparam logic [7:0] STRAP_A_BIT = 8'h08;
  localparam logic [7:0] STRAP_B_BIT = 8'h20;
  localparam int RW_BIT = 0;
  // Register pointers
  localparam logic [7:0] REG_ROW_ORIGIN = 8'h01;
  localparam logic [7:0] REG_COL_ORIGIN = 8'h02;
  localparam logic [7:0] REG_WIN_HEIGHT = 8'h03;
  localparam logic [7:0] REG_WIN_WIDTH = 8'h04;
  localparam logic [7:0] REG_EXPOSURE = 8'h05;
  localparam logic [7:0] REG_READ_MODE = 8'h0D;
  localparam logic [7:0] REG_LAMP_CTRL = 8'h1B;
  // Field positions
  localparam int MODE_WINDOW_BIT = 0;
  localparam int MODE_BIN_BIT = 1;
  localparam int LAMP_ENABLE_BIT = 0;
  // Reset values
  localparam logic [7:0] ROW_ORIGIN_RST = 8'h00;
  localparam logic [7:0] COL_ORIGIN_RST = 8'h00;
  localparam logic [7:0] WIN_SIZE_RST = 8'h00;
  localparam logic [7:0] EXPOSURE_RST = 8'h10;
  localparam logic [7:0] READ_MODE_RST = 8'h00;
  localparam logic [7:0] LAMP_CTRL_RST = 8'h01;
  // Timing: one exposure step lasts EXP_UNIT_NS
  localparam int CLK_PERIOD_NS = 4;
  localparam int EXP_UNIT_NS = 64;
  localparam int EXP_UNIT_CYCLES = (EXP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXP_CNT_W = 16;
  // Bayer phase codes, RGGB order
  localparam logic [1:0] BAYER_R = 2'h0;
  localparam logic [1:0] BAYER_GR = 2'h1;
  localparam logic [1:0] BAYER_GB = 2'h2;
  localparam logic [1:0] BAYER_B = 2'h3;

  typedef enum logic [1:0] {CAP_IDLE, CAP_EXPOSE, CAP_READOUT} cap_state_t;
  typedef enum logic [1:0] {CFG_OFF, CFG_ADDR, CFG_PTR, CFG_DATA} cfg_state_t;
endpackage

// file: hdl/trigger_edge_sync.sv
// Two-stage synchroniser and rising-edge detector for the trigger line
`timescale 1ns/1ns
module trigger_edge_sync
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Trigger
  input wire logic trigger_line,
  output logic trigger_rise
);
  logic sync_meta;
  logic sync_level;
  logic level_prev;

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sync_meta <= 1'b0;
      sync_level <= 1'b0;
      level_prev <= 1'b0;
    end
    else
    begin
      sync_meta <= trigger_line;
      sync_level <= sync_meta;
      level_prev <= sync_level;
    end
  end

  // A held-high line yields one pulse only
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      trigger_rise <= 1'b0;
    else
      trigger_rise <= sync_level & ~level_prev;
  end
endmodule // trigger_edge_sync

// file: hdl/camera_capture_control.sv
// Capture control: trigger, exposure, lamp gate, windowing, binning, config
//
// Overview of operation
// - The sensor answers on one of four write addresses picked by two straps, 0x90 by default.
// - Each capture is timed by the external trigger input, never generated here.
// - The exposure indicator is high exactly while the sensor exposes.
// - With the lamp-enable strap closed the lamps follow the exposure indicator.
// - Clearing bit 0 of register 0x1B stops the lamp gate from following exposure.
// - With windowing on, the full raster is still read but only pixels inside the region of interest are output.
// - The region-of-interest origin can be placed anywhere in the array.
// - With binning on, the monochrome variant merges neighbouring pixels, halving the output count.
// - The monochrome variant outputs one 8-bit grey value per pixel.
// - The colour variant outputs raw RGGB Bayer samples of 8 bits.
`timescale 1ns/1ns
module camera_capture_control
  import camera_capture_pkg::*;
#(
  parameter bit COLOUR_VARIANT = 1'b0
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Straps
  input wire logic addr_select_strap_a,
  input wire logic addr_select_strap_b,
  input wire logic lamp_enable_strap,
  // Capture request
  input wire logic trigger_line,
  // Configuration bus, byte level
  input wire logic cfg_start,
  input wire logic cfg_stop,
  input wire logic cfg_byte_valid,
  input wire logic [7:0] cfg_byte,
  input wire logic cfg_rd_req,
  output logic cfg_ack,
  output logic cfg_rd_valid,
  output logic [7:0] cfg_rd_data,
  // Pixel array access
  output logic array_rd,
  output logic [camera_capture_pkg::ROW_W-1:0] array_row,
  output logic [camera_capture_pkg::COL_W-1:0] array_col,
  input wire logic [camera_capture_pkg::PIX_W-1:0] array_pixel,
  // Pixel stream
  output logic pix_valid,
  output logic [camera_capture_pkg::PIX_W-1:0] pix_data,
  output logic [1:0] bayer_phase,
  output logic frame_start,
  output logic frame_end,
  // Exposure and lamps
  output logic exposure_out,
  output logic lamp_gate_out,
  output logic busy
);
  import camera_capture_pkg::*;

  cap_state_t cap_state;
  cfg_state_t cfg_state;
  logic trigger_rise, strap_taken, cfg_read, scan_last, bin_on, win_on, next_exposure;
  logic pipe_live, pipe_keep, pipe_last;
  logic [7:0] dev_addr, reg_ptr;
  logic [7:0] row_origin, col_origin, win_height, win_width;
  logic [7:0] exposure_steps, read_mode, lamp_ctrl;
  logic [EXP_CNT_W-1:0] exp_count;
  logic [ROW_W-1:0] pipe_row;
  logic [COL_W-1:0] pipe_col;
  logic [PIX_W-1:0] bin_hold;

  // True when pos lies in [origin, origin+size-1]; size 0 spans to the edge
  function automatic logic in_span(input logic [7:0] pos, input logic [7:0] origin,
                                   input logic [7:0] size);
    logic [8:0] end_excl;
    end_excl = (size == 8'h00) ? 9'h100 : ({1'b0, origin} + {1'b0, size});
    return ({1'b0, pos} >= {1'b0, origin}) && ({1'b0, pos} < end_excl);
  endfunction

  function automatic logic [7:0] reg_value(input logic [7:0] ptr);
    case (ptr)
      REG_ROW_ORIGIN: return row_origin;
      REG_COL_ORIGIN: return col_origin;
      REG_WIN_HEIGHT: return win_height;
      REG_WIN_WIDTH: return win_width;
      REG_EXPOSURE: return exposure_steps;
      REG_READ_MODE: return read_mode;
      REG_LAMP_CTRL: return lamp_ctrl;
      default: return 8'h00;
    endcase
  endfunction

  trigger_edge_sync u_trigger_sync
  (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .trigger_line(trigger_line),
    .trigger_rise(trigger_rise)
  );

  // Address straps are caught once after reset release; moving them later has no effect
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      strap_taken <= 1'b0;
      dev_addr <= DEV_ADDR_BASE;
    end
    else if (!strap_taken)
    begin
      strap_taken <= 1'b1;
      dev_addr <= DEV_ADDR_BASE | (addr_select_strap_a ? STRAP_A_BIT : 8'h00)
                  | (addr_select_strap_b ? STRAP_B_BIT : 8'h00);
    end
  end

  // Configuration transaction sequencing
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_state <= CFG_OFF;
      cfg_read <= 1'b0;
      cfg_ack <= 1'b0;
    end
    else
    begin
      cfg_ack <= 1'b0;
      if (cfg_stop)
        cfg_state <= CFG_OFF;
      else if (cfg_start)
        cfg_state <= CFG_ADDR;
      else if (cfg_byte_valid)
      begin
        case (cfg_state)
          CFG_ADDR:
          begin
            // Upper seven bits carry the address; the host's 7-bit form is this shifted
            if (cfg_byte[7:1] == dev_addr[7:1])
            begin
              cfg_ack <= 1'b1;
              cfg_read <= cfg_byte[RW_BIT];
              cfg_state <= cfg_byte[RW_BIT] ? CFG_DATA : CFG_PTR;
            end
            else
              cfg_state <= CFG_OFF;
          end
          CFG_PTR:
          begin
            cfg_ack <= 1'b1;
            cfg_state <= CFG_DATA;
          end
          CFG_DATA:
            cfg_ack <= !cfg_read;
          default:
            cfg_state <= CFG_OFF;
        endcase
      end
    end
  end

  // Register pointer auto-increments after each data byte written or read
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      reg_ptr <= 8'h00;
    else if (cfg_byte_valid && !cfg_start && !cfg_stop && cfg_state == CFG_PTR)
      reg_ptr <= cfg_byte;
    else if (cfg_byte_valid && !cfg_start && !cfg_stop && cfg_state == CFG_DATA
             && !cfg_read)
      reg_ptr <= reg_ptr + 8'h01;
    else if (cfg_rd_req && cfg_state == CFG_DATA && cfg_read)
      reg_ptr <= reg_ptr + 8'h01;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_rd_valid <= 1'b0;
      cfg_rd_data <= 8'h00;
    end
    else
    begin
      cfg_rd_valid <= cfg_rd_req && cfg_state == CFG_DATA && cfg_read;
      if (cfg_rd_req && cfg_state == CFG_DATA && cfg_read)
        cfg_rd_data <= reg_value(reg_ptr);
    end
  end

  // Register file
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      row_origin <= ROW_ORIGIN_RST;
      col_origin <= COL_ORIGIN_RST;
      win_height <= WIN_SIZE_RST;
      win_width <= WIN_SIZE_RST;
      exposure_steps <= EXPOSURE_RST;
      read_mode <= READ_MODE_RST;
      lamp_ctrl <= LAMP_CTRL_RST;
    end
    else if (cfg_byte_valid && !cfg_start && !cfg_stop && cfg_state == CFG_DATA
             && !cfg_read)
    begin
      case (reg_ptr)
        REG_ROW_ORIGIN: row_origin <= cfg_byte;
        REG_COL_ORIGIN: col_origin <= cfg_byte;
        REG_WIN_HEIGHT: win_height <= cfg_byte;
        REG_WIN_WIDTH: win_width <= cfg_byte;
        REG_EXPOSURE: exposure_steps <= cfg_byte;
        REG_READ_MODE: read_mode <= cfg_byte;
        REG_LAMP_CTRL: lamp_ctrl <= cfg_byte;
        default: ;
      endcase
    end
  end

  assign win_on = read_mode[MODE_WINDOW_BIT];
  // Bayer neighbours carry different filters, so colour parts never bin
  assign bin_on = read_mode[MODE_BIN_BIT] && !COLOUR_VARIANT;
  assign scan_last = (array_row == '1) && (array_col == '1);

  // Capture sequence; triggers during a capture are ignored
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cap_state <= CAP_IDLE;
      exp_count <= '0;
    end
    else
    begin
      case (cap_state)
        CAP_IDLE:
          if (trigger_rise)
          begin
            cap_state <= CAP_EXPOSE;
            exp_count <= EXP_CNT_W'(((exposure_steps == 8'h00) ? 8'h01 : exposure_steps)
                         * EXP_UNIT_CYCLES - 1);
          end
        CAP_EXPOSE:
          if (exp_count == '0)
            cap_state <= CAP_READOUT;
          else
            exp_count <= exp_count - 1'b1;
        CAP_READOUT:
          if (scan_last)
            cap_state <= CAP_IDLE;
        default:
          cap_state <= CAP_IDLE;
      endcase
    end
  end

  // Indicator mirrors the expose state edge for edge
  always_comb
  begin
    next_exposure = exposure_out;
    if (cap_state == CAP_IDLE && trigger_rise)
      next_exposure = 1'b1;
    else if (cap_state == CAP_EXPOSE && exp_count == '0)
      next_exposure = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      exposure_out <= 1'b0;
      lamp_gate_out <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      exposure_out <= next_exposure;
      lamp_gate_out <= next_exposure && lamp_enable_strap
                       && lamp_ctrl[LAMP_ENABLE_BIT];
      busy <= (cap_state == CAP_IDLE) ? trigger_rise
              : !(cap_state == CAP_READOUT && scan_last);
    end
  end

  // Array scan: one address per cycle, full raster
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      array_rd <= 1'b0;
      array_row <= '0;
      array_col <= '0;
    end
    else
    begin
      array_rd <= (cap_state == CAP_EXPOSE && exp_count == '0)
                  || (cap_state == CAP_READOUT && !scan_last);
      if (cap_state == CAP_READOUT)
      begin
        array_col <= array_col + 1'b1;
        if (array_col == '1)
          array_row <= array_row + 1'b1;
      end
      else
      begin
        array_row <= '0;
        array_col <= '0;
      end
    end
  end

  // Pixel arrives one cycle after its address; mark whether it is kept
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pipe_live <= 1'b0;
      pipe_keep <= 1'b0;
      pipe_last <= 1'b0;
      pipe_row <= '0;
      pipe_col <= '0;
    end
    else
    begin
      pipe_live <= array_rd;
      pipe_keep <= !win_on || (in_span(array_row, row_origin, win_height)
                   && in_span(array_col, col_origin, win_width));
      pipe_last <= scan_last;
      pipe_row <= array_row;
      pipe_col <= array_col;
    end
  end

  // Horizontal pair binning: even column held, odd column emits the mean
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      bin_hold <= '0;
    else if (pipe_live && pipe_keep && !pipe_col[0])
      bin_hold <= array_pixel;
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pix_valid <= 1'b0;
      pix_data <= '0;
      bayer_phase <= BAYER_R;
      frame_start <= 1'b0;
      frame_end <= 1'b0;
    end
    else
    begin
      pix_valid <= pipe_live && pipe_keep && (!bin_on || pipe_col[0]);
      if (bin_on)
        pix_data <= PIX_W'(({1'b0, bin_hold} + {1'b0, array_pixel}) >> 1);
      else
        pix_data <= array_pixel;
      bayer_phase <= {pipe_row[0], pipe_col[0]};
      frame_start <= pipe_live && pipe_row == '0 && pipe_col == '0;
      frame_end <= pipe_live && pipe_last;
    end
  end
endmodule // camera_capture_control

// file: verification/camera_capture_control_props.sv
// Concurrent checks on the camera capture control ports
`timescale 1ns/1ns
module camera_capture_control_props
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Watched ports
  input wire logic lamp_enable_strap,
  input wire logic trigger_line,
  input wire logic cfg_byte_valid,
  input wire logic cfg_rd_req,
  input wire logic cfg_ack,
  input wire logic cfg_rd_valid,
  input wire logic array_rd,
  input wire logic pix_valid,
  input wire logic exposure_out,
  input wire logic lamp_gate_out,
  input wire logic busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [15:0] exp_len;
  // Length of the current exposure, checked when it ends
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      exp_len <= 16'h0000;
    else if (exposure_out)
      exp_len <= exp_len + 16'h0001;
    else
      exp_len <= 16'h0000;
  end
  property p_exp_len;
    $fell(exposure_out) |-> exp_len != 16'h0000 && exp_len[3:0] == 4'h0;
  endproperty
  a_exp_len: assert property (p_exp_len) else $error("exposure length off");
  property p_scan_start;
    $fell(exposure_out) |-> array_rd;
  endproperty
  a_scan_start: assert property (p_scan_start) else $error("no scan after exposure");
  property p_expose_only;
    exposure_out |-> !array_rd && busy;
  endproperty
  a_expose_only: assert property (p_expose_only) else $error("read during exposure");
  property p_trig_cause;
    $rose(exposure_out) |-> $past(trigger_line, 4);
  endproperty
  a_trig_cause: assert property (p_trig_cause) else $error("exposure without trigger");
  property p_lamp;
    lamp_gate_out |-> exposure_out && $past(lamp_enable_strap);
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp lit outside exposure");
  property p_ack_cause;
    cfg_ack |-> $past(cfg_byte_valid);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without byte");
  property p_rd_cause;
    cfg_rd_valid |-> $past(cfg_rd_req);
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("read data unasked");
  property p_pix_cause;
    pix_valid |-> $past(array_rd, 2);
  endproperty
  a_pix_cause: assert property (p_pix_cause) else $error("pixel without read");
endmodule // camera_capture_control_props
bind camera_capture_control camera_capture_control_props chk_i (.sys_clk, .nrst,
  .lamp_enable_strap, .trigger_line, .cfg_byte_valid, .cfg_rd_req, .cfg_ack,
  .cfg_rd_valid, .array_rd, .pix_valid, .exposure_out, .lamp_gate_out, .busy);

// file: verification/pixel_array_model.sv
// Behavioural pixel array answering raster reads one cycle later
`timescale 1ns/1ns
module pixel_array_model
(
  // Clock
  input wire logic sys_clk,
  // Array access
  input wire logic array_rd,
  input wire logic [7:0] array_row,
  input wire logic [7:0] array_col,
  output logic [7:0] array_pixel
);
  // Value names its coordinates; toggles when idle so stale data never passes
  initial array_pixel = 8'h00;
  always @(posedge sys_clk)
  begin
    if (array_rd)
      array_pixel <= {array_row[3:0], array_col[3:0]};
    else
      array_pixel <= ~array_pixel;
  end
endmodule // pixel_array_model

// file: verification/camera_capture_control_tb.sv
// Self-checking testbench for the camera capture control
`timescale 1ns/1ns
module camera_capture_control_tb;
  import camera_capture_pkg::*;
  logic sys_clk, nrst, strap_a, strap_b, lamp_strap, trig, c_start, c_stop, c_valid, c_rdreq;
  logic ack, rd_valid, a_rd, pv, fs, fe, expo, lamp, busy;
  logic [7:0] c_byte, rd_data, row, col, pixel, pdata;
  logic [1:0] phase;
  int miscompares, samples_checked;
  camera_capture_control DUT (.sys_clk(sys_clk), .nrst(nrst), .addr_select_strap_a(strap_a),
    .addr_select_strap_b(strap_b), .lamp_enable_strap(lamp_strap), .trigger_line(trig),
    .cfg_start(c_start), .cfg_stop(c_stop), .cfg_byte_valid(c_valid), .cfg_byte(c_byte),
    .cfg_rd_req(c_rdreq), .cfg_ack(ack), .cfg_rd_valid(rd_valid), .cfg_rd_data(rd_data),
    .array_rd(a_rd), .array_row(row), .array_col(col), .array_pixel(pixel),
    .pix_valid(pv), .pix_data(pdata), .bayer_phase(phase), .frame_start(fs),
    .frame_end(fe), .exposure_out(expo), .lamp_gate_out(lamp), .busy(busy));
  pixel_array_model array_i (.sys_clk(sys_clk), .array_rd(a_rd), .array_row(row),
    .array_col(col), .array_pixel(pixel));
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("%0d checks, %0d miscompares", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic pulse(logic stop);
    @(posedge sys_clk);
    c_start <= !stop;
    c_stop <= stop;
    @(posedge sys_clk);
    c_start <= 1'b0;
    c_stop <= 1'b0;
  endtask
  // Ack may land in either of the two cycles after the byte is taken
  task automatic send(logic [7:0] b, output logic acked);
    @(posedge sys_clk);
    c_valid <= 1'b1;
    c_byte <= b;
    @(posedge sys_clk);
    c_valid <= 1'b0;
    c_byte <= ~b;
    acked = 1'b0;
    repeat (2)
    begin
      @(negedge sys_clk);
      acked = acked | (ack === 1'b1);
    end
  endtask
  task automatic cfg_write(logic [7:0] dev, ptr, data, logic exp_ack);
    logic a;
    pulse(1'b0);
    send(dev, a);
    chk("address ack", a, exp_ack);
    if (exp_ack)
    begin
      send(ptr, a);
      send(data, a);
      chk("data ack", a, 1'b1);
    end
    pulse(1'b1);
  endtask
  task automatic cfg_read(logic [7:0] dev, ptr, exp);
    logic a;
    int k;
    pulse(1'b0);
    send(dev, a);
    send(ptr, a);
    pulse(1'b1);
    pulse(1'b0);
    send(dev | 8'h01, a);
    chk("read address ack", a, 1'b1);
    @(posedge sys_clk);
    c_rdreq <= 1'b1;
    @(posedge sys_clk);
    c_rdreq <= 1'b0;
    for (k = 0; k < 4 && rd_valid !== 1'b1; k++)
      @(negedge sys_clk);
    chk("read valid", rd_valid, 1'b1);
    if (rd_valid !== 1'b1)
      test_done();
    chk("read data", rd_data, exp);
    pulse(1'b1);
  endtask
  // Trigger stays high past exposure, so a single capture must follow
  task automatic capture(logic lamp_on, int npix, logic [7:0] first, last);
    int k, hi, n, idle, nfs, nfe;
    logic [7:0] f, l;
    logic [1:0] ph;
    hi = 0;
    n = 0;
    idle = 0;
    nfs = 0;
    nfe = 0;
    @(posedge sys_clk);
    trig <= 1'b1;
    for (k = 0; k < 8 && expo !== 1'b1; k++)
      @(negedge sys_clk);
    chk("exposure start", expo, 1'b1);
    if (expo !== 1'b1)
      test_done();
    while (expo === 1'b1 && hi < 300)
    begin
      chk("lamp gate", lamp, lamp_on);
      hi++;
      @(negedge sys_clk);
    end
    chk("exposure cycles", hi[15:0], 16'h0010);
    if (hi == 300)
      test_done();
    @(posedge sys_clk);
    trig <= 1'b0;
    if (npix < 0)
      return;
    for (k = 0; k < 70000 && idle < 5; k++)
    begin
      @(negedge sys_clk);
      if (pv === 1'b1)
      begin
        if (n == 0)
        begin
          f = pdata;
          ph = phase;
        end
        l = pdata;
        n++;
      end
      if (fs === 1'b1)
        nfs++;
      if (fe === 1'b1)
        nfe++;
      if (busy !== 1'b1)
        idle++;
    end
    if (k == 70000)
    begin
      $display("unexpected scan end: expected busy low, seen high");
      miscompares++;
      test_done();
    end
    chk("window pixels", n[15:0], npix[15:0]);
    chk("first pixel", f, first);
    chk("last pixel", l, last);
    chk("frame starts", nfs[15:0], 16'h0001);
    chk("frame ends", nfe[15:0], 16'h0001);
    chk("first phase", ph, BAYER_GB);
  endtask
  task automatic test_addr();
    cfg_write(8'h90, REG_LAMP_CTRL, 8'h00, 1'b0);
    cfg_write(8'h4C << 1, REG_LAMP_CTRL, 8'h00, 1'b1);
    cfg_read(8'h98, REG_LAMP_CTRL, 8'h00);
    $display("addressing test done");
  endtask
  // Binning on, no window: pairs (0,2k),(0,2k+1) give the even pixel value
  task automatic test_lamp_off();
    int k, n;
    logic [7:0] v [2];
    n = 0;
    cfg_write(8'h98, REG_EXPOSURE, 8'h01, 1'b1);
    cfg_write(8'h98, REG_READ_MODE, 8'h02, 1'b1);
    capture(1'b0, -1, 8'h00, 8'h00);
    for (k = 0; k < 20; k++)
    begin
      @(negedge sys_clk);
      if (pv === 1'b1)
      begin
        if (n < 2)
          v[n] = pdata;
        n++;
      end
    end
    chk("binned pixels", n[15:0], 16'h0009);
    chk("first binned", v[0], 8'h00);
    chk("second binned", v[1], 8'h02);
    chk("scan running", a_rd, 1'b1);
    @(posedge sys_clk);
    strap_a <= 1'b0;
    do_reset();
    chk("busy after reset", busy, 1'b0);
    chk("read after reset", a_rd, 1'b0);
    $display("lamp off and abort test done");
  endtask
  task automatic test_window();
    cfg_read(8'h90, REG_LAMP_CTRL, LAMP_CTRL_RST);
    cfg_write(8'h90, REG_EXPOSURE, 8'h01, 1'b1);
    cfg_write(8'h90, REG_ROW_ORIGIN, 8'h01, 1'b1);
    cfg_write(8'h90, REG_COL_ORIGIN, 8'h02, 1'b1);
    cfg_write(8'h90, REG_WIN_HEIGHT, 8'h03, 1'b1);
    cfg_write(8'h90, REG_WIN_WIDTH, 8'h04, 1'b1);
    cfg_write(8'h90, REG_READ_MODE, 8'h01, 1'b1);
    capture(1'b1, 12, 8'h12, 8'h35);
    $display("window test done");
  endtask
  initial
  begin
    nrst = 1'b0;
    strap_a = 1'b1;
    strap_b = 1'b0;
    lamp_strap = 1'b1;
    trig = 1'b0;
    c_start = 1'b0;
    c_stop = 1'b0;
    c_valid = 1'b0;
    c_byte = 8'h00;
    c_rdreq = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    test_addr();
    test_lamp_off();
    test_window();
    test_done();
  end
endmodule // camera_capture_control_tb
